// *** acd_consts.svh ***
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH

// Register offsets on the register port
`define ACD_ADDR_BG_SEL 7'h00
`define ACD_ADDR_SYSCAL 7'h01
`define ACD_ADDR_CAL_CHAN 7'h02
`define ACD_ADDR_FGA_EN 7'h03
`define ACD_ADDR_STATUS 7'h04
`define ACD_ADDR_SET_BASE 3'h1
// Field inside a per-set block: addr = {1, set[1:0], field[1:0]} from 0x10
`define ACD_FLD_OFFSET 2'h0
`define ACD_FLD_GAIN 2'h1
`define ACD_FLD_SCALE 2'h2
`define ACD_FLD_SHIFT 2'h3

// Reset values
`define ACD_RST_OFFSET 16'h0000
`define ACD_RST_GAIN 16'h8000
`define ACD_RST_SCALE 16'h0001
`define ACD_RST_SHIFT 4'h0
`define ACD_GAIN_FRAC 15

// Divider iteration count
`define ACD_DIV_CYCLES 6'h20

`endif

// *** acd_pkg.sv ***
package acd_pkg;

  // Background calibration setting
  typedef enum logic [1:0] {
    BG_CAL_OFF = 2'b00,
    BG_OFFSET_CORRECT_GAIN_ESTIMATE = 2'b01,
    BG_OFFSET_GAIN_CORRECT = 2'b10,
    BG_OFFSET_GAIN_ESTIMATE = 2'b11
  } acd_bg_mode_type;

  // System calibration control codes
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_OFFSET_DET = 2'b01,
    SC_RSVD = 2'b10,
    SC_GAIN_DET = 2'b11
  } acd_syscal_type;

  // Datapath sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BG = 3'b001,
    ST_DIV = 3'b010,
    ST_WAIT = 3'b011,
    ST_POST = 3'b100
  } acd_state_type;

endpackage : acd_pkg

// *** acd_divider.sv ***
`timescale 1ns/1ps
`include "acd_consts.svh"
// Signed by unsigned restoring divider, one quotient bit per cycle
module acd_divider (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Request
  input wire logic start_i,
  input wire logic signed [31:0] dividend_i,
  input wire logic [15:0] divisor_i,
  // Answer
  output logic done_o,
  output logic signed [31:0] quot_o
);
  import acd_pkg::*;

  logic [31:0] quo_q;
  logic [15:0] rem_q;
  logic [15:0] dv_q;
  logic neg_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic [16:0] trial;
  logic fits;

  // Trial subtraction of the next remainder bit
  assign trial = {rem_q, quo_q[31]};
  assign fits = trial >= {1'b0, dv_q};
  // Zero divisor pins the quotient at the extreme of the dividend's sign
  assign quot_o = (dv_q == 16'h0000) ?
    (neg_q ? 32'sh8000_0000 : 32'sh7fff_ffff) :
    (neg_q ? -$signed(quo_q) : $signed(quo_q));

  // Iteration engine
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quo_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
      dv_q <= 16'h0000;
      neg_q <= 1'b0;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= busy_q && (cnt_q == 6'h01);
      if (start_i) begin
        quo_q <= dividend_i[31] ? 32'(-dividend_i) : dividend_i;
        neg_q <= dividend_i[31];
        rem_q <= 16'h0000;
        dv_q <= divisor_i;
        cnt_q <= `ACD_DIV_CYCLES;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= fits ? 16'(trial - {1'b0, dv_q}) : trial[15:0];
        quo_q <= {quo_q[30:0], fits};
        cnt_q <= cnt_q - 6'h01;
        busy_q <= cnt_q != 6'h01;
      end
    end
  end

endmodule : acd_divider

// *** acd_post_scaler.sv ***
`timescale 1ns/1ps
// Multiply by the scale value, shift right, clamp to 16 bits
module acd_post_scaler #(
  parameter int SCALE_W = 16,
  parameter int SHIFT_W = 4
) (
  // Operands
  input wire logic signed [15:0] value_i,
  input wire logic [SCALE_W-1:0] scale_i,
  input wire logic [SHIFT_W-1:0] shift_i,
  // Result
  output logic signed [15:0] result_o
);
  import acd_pkg::*;

  logic signed [SCALE_W+16:0] prod;
  logic signed [SCALE_W+16:0] shifted;
  logic over_hi;
  logic over_lo;

  // Full-width product keeps the sign before the shift
  assign prod = value_i * $signed({1'b0, scale_i});
  assign shifted = prod >>> shift_i;
  assign over_hi = shifted > $signed((SCALE_W+17)'(32767));
  assign over_lo = shifted < $signed(-(SCALE_W+17)'(32768));
  assign result_o = over_hi ? 16'sh7fff : over_lo ? -16'sh8000 :
    shifted[15:0];

endmodule : acd_post_scaler

// *** acd_cal_datapath.sv ***
`timescale 1ns/1ps
`include "acd_consts.svh"
// Background correction, system calibration and post scaling of results
module acd_cal_datapath #(
  parameter int SETS = 4,
  parameter int SCALE_W = 16,
  parameter int SHIFT_W = 4
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register port from the serial decoder
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Raw conversion results from the filter
  input wire logic raw_valid_i,
  input wire logic [2:0] raw_chan_i,
  input wire logic signed [15:0] raw_data_i,
  // Background measurements from the modulator
  input wire logic meas_valid_i,
  input wire logic [1:0] meas_set_i,
  input wire logic signed [15:0] meas_offset_i,
  input wire logic [15:0] meas_gain_i,
  // Factory coefficients from nonvolatile storage
  input wire logic nv_load_i,
  input wire logic [1:0] nv_set_i,
  input wire logic signed [15:0] nv_offset_i,
  input wire logic [15:0] nv_gain_i,
  // Conversion sequencer requests
  output logic conv_restart_o,
  output logic [2:0] conv_chan_o,
  output logic cal_slot_o,
  output logic [1:0] bg_track_o,
  // Calibrated results
  output logic data_valid_o,
  output logic [2:0] data_chan_o,
  output logic signed [15:0] data_o
);
  import acd_pkg::*;

  // Map a channel onto its coefficient set
  function automatic logic [1:0] chan_set(input logic [2:0] ch);
    chan_set = ch[2] ? ch[1:0] : ch[1:0];
  endfunction : chan_set

  // Clamp a wide signed value to the 16-bit output range
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767)
      sat16 = 16'sh7fff;
    else if (v < -48'sd32768)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // Control registers
  acd_bg_mode_type bg_mode_q;
  acd_syscal_type syscal_q;
  logic [2:0] cal_chan_q;
  logic fga_en_q;
  logic armed_q;
  acd_state_type state_q;
  acd_state_type state_d;

  // Per-set storage
  logic signed [15:0] sys_off_q [SETS];
  logic [15:0] sys_gain_q [SETS];
  logic [SCALE_W-1:0] scale_q [SETS];
  logic [SHIFT_W-1:0] shift_q [SETS];
  logic signed [15:0] bg_off_q [SETS];
  logic [15:0] bg_gain_q [SETS];

  // Pipeline registers
  logic signed [15:0] x_q;
  logic [2:0] chan_q;
  logic [1:0] set_q;
  logic signed [15:0] bg_q;
  logic signed [15:0] res_q;
  logic is_cal_q;

  // Register decode
  logic set_hit;
  logic [1:0] wr_set;
  logic [1:0] wr_fld;
  logic syscal_wr;
  logic syscal_go;
  assign set_hit = reg_addr_i[6:4] == `ACD_ADDR_SET_BASE;
  assign wr_set = reg_addr_i[3:2];
  assign wr_fld = reg_addr_i[1:0];
  assign syscal_wr = reg_wr_i && reg_addr_i == `ACD_ADDR_SYSCAL;
  assign syscal_go = syscal_wr && (reg_wdata_i[1:0] == SC_OFFSET_DET ||
    reg_wdata_i[1:0] == SC_GAIN_DET);

  // Background correction of the latched raw sample
  logic signed [16:0] bg_diff;
  logic signed [33:0] bg_prod;
  logic signed [15:0] bg_val;
  assign bg_diff = 17'(x_q) - 17'(bg_off_q[set_q]);
  assign bg_prod = bg_diff * $signed({1'b0, bg_gain_q[set_q]});
  assign bg_val = (bg_mode_q == BG_CAL_OFF) ? x_q :
    sat16(48'(bg_prod >>> `ACD_GAIN_FRAC));

  // System offset removal ahead of the division
  logic signed [16:0] sys_diff;
  logic signed [31:0] dividend;
  logic [15:0] divisor;
  logic cal_hit;
  logic gain_run;
  assign sys_diff = 17'(bg_q) - 17'(sys_off_q[set_q]);
  assign dividend = {sys_diff, 15'h0000};
  assign divisor = sys_gain_q[set_q];
  assign cal_hit = armed_q && chan_q == cal_chan_q;
  assign gain_run = is_cal_q && syscal_q == SC_GAIN_DET;

  // Division and result shaping
  logic div_start;
  logic div_done;
  logic signed [31:0] quot;
  logic [15:0] gain_new;
  logic signed [15:0] scaled;
  assign div_start = ce_i && state_q == ST_DIV &&
    !(cal_hit && syscal_q == SC_OFFSET_DET);
  assign gain_new = quot[31] ? 16'h0000 :
    (|quot[30:16]) ? 16'hffff : quot[15:0];

  acd_divider u_div (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .start_i(div_start),
    .dividend_i(dividend),
    .divisor_i(divisor),
    .done_o(div_done),
    .quot_o(quot)
  );

  acd_post_scaler #(
    .SCALE_W(SCALE_W),
    .SHIFT_W(SHIFT_W)
  ) u_scale (
    .value_i(res_q),
    .scale_i(scale_q[set_q]),
    .shift_i(shift_q[set_q]),
    .result_o(scaled)
  );

  // Hardware-side coefficient writes
  logic hw_off_wr;
  logic hw_gain_wr;
  assign hw_off_wr = state_q == ST_DIV && cal_hit &&
    syscal_q == SC_OFFSET_DET;
  assign hw_gain_wr = state_q == ST_WAIT && div_done && gain_run;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (raw_valid_i)
          state_d = ST_BG;
      end
      ST_BG: state_d = ST_DIV;
      ST_DIV: state_d = hw_off_wr ? ST_IDLE : ST_WAIT;
      ST_WAIT: begin
        if (div_done)
          state_d = gain_run ? ST_IDLE : ST_POST;
      end
      ST_POST: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Per-set coefficient banks; hardware updates beat a host write
  generate
    for (genvar s = 0; s < SETS; s++) begin : g_set
      logic host_wr;
      logic own_set;
      logic meas_hit;
      logic nv_hit;
      assign host_wr = reg_wr_i && set_hit && wr_set == 2'(s);
      assign own_set = set_q == 2'(s);
      assign meas_hit = meas_valid_i && meas_set_i == 2'(s);
      assign nv_hit = nv_load_i && nv_set_i == 2'(s);

      // System calibration coefficients, scale and shift
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          sys_off_q[s] <= `ACD_RST_OFFSET;
          sys_gain_q[s] <= `ACD_RST_GAIN;
          scale_q[s] <= SCALE_W'(`ACD_RST_SCALE);
          shift_q[s] <= SHIFT_W'(`ACD_RST_SHIFT);
        end else if (ce_i) begin
          if (hw_off_wr && own_set)
            sys_off_q[s] <= bg_q;
          else if (host_wr && wr_fld == `ACD_FLD_OFFSET)
            sys_off_q[s] <= reg_wdata_i;
          if (hw_gain_wr && own_set)
            sys_gain_q[s] <= gain_new;
          else if (host_wr && wr_fld == `ACD_FLD_GAIN)
            sys_gain_q[s] <= reg_wdata_i;
          if (host_wr && wr_fld == `ACD_FLD_SCALE)
            scale_q[s] <= reg_wdata_i[SCALE_W-1:0];
          if (host_wr && wr_fld == `ACD_FLD_SHIFT)
            shift_q[s] <= reg_wdata_i[SHIFT_W-1:0];
        end
      end

      // Background coefficients: track in correction, hold in estimation
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          bg_off_q[s] <= `ACD_RST_OFFSET;
          bg_gain_q[s] <= `ACD_RST_GAIN;
        end else if (ce_i) begin
          if (meas_hit && bg_track_o[0])
            bg_off_q[s] <= meas_offset_i;
          else if (nv_hit)
            bg_off_q[s] <= nv_offset_i;
          if (meas_hit && bg_track_o[1])
            bg_gain_q[s] <= meas_gain_i;
          else if (nv_hit)
            bg_gain_q[s] <= nv_gain_i;
        end
      end
    end
  endgenerate

  // Host control registers and determination bookkeeping
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bg_mode_q <= BG_CAL_OFF;
      syscal_q <= SC_IDLE;
      cal_chan_q <= 3'h0;
      fga_en_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == `ACD_ADDR_BG_SEL)
        bg_mode_q <= acd_bg_mode_type'(reg_wdata_i[1:0]);
      if (reg_wr_i && reg_addr_i == `ACD_ADDR_CAL_CHAN)
        cal_chan_q <= reg_wdata_i[2:0];
      if (reg_wr_i && reg_addr_i == `ACD_ADDR_FGA_EN)
        fga_en_q <= reg_wdata_i[0];
      if (syscal_wr) begin
        syscal_q <= acd_syscal_type'(reg_wdata_i[1:0]);
        armed_q <= syscal_go;
      end else if (hw_off_wr || hw_gain_wr) begin
        syscal_q <= SC_IDLE;
        armed_q <= 1'b0;
      end else if (state_q == ST_DIV && cal_hit) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Datapath pipeline
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      x_q <= 16'sh0000;
      chan_q <= 3'h0;
      set_q <= 2'h0;
      bg_q <= 16'sh0000;
      res_q <= 16'sh0000;
      is_cal_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      if (state_q == ST_IDLE && raw_valid_i) begin
        x_q <= raw_data_i;
        chan_q <= raw_chan_i;
        set_q <= chan_set(raw_chan_i);
      end
      if (state_q == ST_BG)
        bg_q <= bg_val;
      if (state_q == ST_DIV)
        is_cal_q <= cal_hit;
      if (state_q == ST_WAIT && div_done)
        res_q <= sat16(48'(quot));
    end
  end

  // Sequencer requests and result outputs
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_restart_o <= 1'b0;
      conv_chan_o <= 3'h0;
      cal_slot_o <= 1'b0;
      bg_track_o <= 2'b00;
      data_valid_o <= 1'b0;
      data_chan_o <= 3'h0;
      data_o <= 16'sh0000;
    end else if (ce_i) begin
      // A fresh conversion so no stale sample feeds the coefficient
      conv_restart_o <= syscal_go;
      if (syscal_go)
        conv_chan_o <= cal_chan_q;
      // Extra gain measurement slot per conversion costs output rate
      cal_slot_o <= raw_valid_i && state_q == ST_IDLE &&
        bg_mode_q == BG_OFFSET_GAIN_CORRECT && !fga_en_q;
      bg_track_o <= {bg_mode_q == BG_OFFSET_GAIN_CORRECT,
        bg_mode_q == BG_OFFSET_CORRECT_GAIN_ESTIMATE ||
        bg_mode_q == BG_OFFSET_GAIN_CORRECT};
      data_valid_o <= state_q == ST_POST;
      if (state_q == ST_POST) begin
        data_chan_o <= chan_q;
        data_o <= scaled;
      end
    end
  end

  // Read mux, registered on a read strobe
  logic [15:0] rd_mux;
  assign rd_mux =
    (reg_addr_i == `ACD_ADDR_BG_SEL) ? {14'h0000, bg_mode_q} :
    (reg_addr_i == `ACD_ADDR_SYSCAL) ? {14'h0000, syscal_q} :
    (reg_addr_i == `ACD_ADDR_CAL_CHAN) ? {13'h0000, cal_chan_q} :
    (reg_addr_i == `ACD_ADDR_FGA_EN) ? {15'h0000, fga_en_q} :
    (reg_addr_i == `ACD_ADDR_STATUS) ? {12'h000, armed_q, state_q} :
    !set_hit ? 16'h0000 :
    (wr_fld == `ACD_FLD_OFFSET) ? sys_off_q[wr_set] :
    (wr_fld == `ACD_FLD_GAIN) ? sys_gain_q[wr_set] :
    (wr_fld == `ACD_FLD_SCALE) ? 16'(scale_q[wr_set]) :
    16'(shift_q[wr_set]);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      reg_rdata_o <= 16'h0000;
    else if (ce_i && reg_rd_i)
      reg_rdata_o <= rd_mux;
  end

endmodule : acd_cal_datapath

// *** acd_cal_datapath_properties.sv ***
`timescale 1ns/1ps
module acd_cal_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Requests
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic raw_valid_i,
  input wire logic [2:0] raw_chan_i,
  // Answers
  input wire logic conv_restart_o,
  input wire logic cal_slot_o,
  input wire logic [1:0] bg_track_o,
  input wire logic data_valid_o,
  input wire logic [2:0] data_chan_o,
  input wire logic signed [15:0] data_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Control writes; codes 0x1 and 0x3 both carry bit 0
  wire cmd_w = ce_i && reg_wr_i && reg_addr_i == 7'h01;
  wire det_w = cmd_w && reg_wdata_i[0];
  wire full_w = ce_i && reg_wr_i && reg_addr_i == 7'h00 &&
    reg_wdata_i[1:0] == 2'b10;

  a_det_restart: assert property (det_w |=> conv_restart_o)
    else $error("no fresh conversion after determination command");
  a_restart_cause: assert property (conv_restart_o |-> $past(det_w))
    else $error("fresh conversion without a command");
  a_restart_pulse: assert property (conv_restart_o |=> !conv_restart_o)
    else $error("restart request longer than one cycle");
  a_valid_latency: assert property (
    data_valid_o |-> $past(raw_valid_i, 37))
    else $error("result without raw input 37 cycles before");
  a_chan_follows: assert property (
    data_valid_o |-> data_chan_o == $past(raw_chan_i, 37))
    else $error("result channel differs from input channel");
  a_data_held: assert property (!data_valid_o |-> $stable(data_o))
    else $error("result word changed without valid");
  a_valid_pulse: assert property (data_valid_o |=> !data_valid_o)
    else $error("result valid longer than one cycle");
  a_slot_cause: assert property (
    cal_slot_o |-> $past(raw_valid_i) && bg_track_o == 2'b11)
    else $error("extra slot outside full correction");
  a_track_full: assert property (
    full_w |=> ##[0:1] bg_track_o == 2'b11)
    else $error("full correction not tracking both values");

  c_restart: cover property (det_w ##1 conv_restart_o);
  c_result: cover property (data_valid_o);
  c_slot: cover property (cal_slot_o);
endmodule : acd_cal_checker

bind acd_cal_datapath acd_cal_checker u_acd_cal_checker (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .raw_valid_i(raw_valid_i), .raw_chan_i(raw_chan_i),
  .conv_restart_o(conv_restart_o), .cal_slot_o(cal_slot_o),
  .bg_track_o(bg_track_o), .data_valid_o(data_valid_o),
  .data_chan_o(data_chan_o), .data_o(data_o)
);

// *** acd_host_model.sv ***
`timescale 1ns/1ps
module acd_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Register port toward the device
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [6:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 16'h0000;
  end

  // One strobe cycle; idle lines inverted so stale values never match
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr_reg

  // Read word is registered at the strobe edge
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge ref_clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd_reg

  // Offset run always precedes the gain run of a channel
  task automatic det_offset(input logic [2:0] ch);
    wr_reg(7'h02, {13'h0, ch});
    wr_reg(7'h01, 16'h0001);
  endtask : det_offset

  task automatic det_gain(input logic [1:0] s, input logic [15:0] target);
    wr_reg({3'h1, s, 2'h1}, target);
    wr_reg(7'h01, 16'h0003);
  endtask : det_gain

  // Shift kept near the base-two log of the scale value
  task automatic set_scale(input logic [1:0] s, input logic [15:0] scale,
                           input logic [3:0] shift);
    wr_reg({3'h1, s, 2'h2}, scale);
    wr_reg({3'h1, s, 2'h3}, {12'h0, shift});
  endtask : set_scale
endmodule : acd_host_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import acd_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr, reg_rd, conv_restart, cal_slot, data_valid, slot;
  logic raw_valid = 1'b0;
  logic meas_valid = 1'b0;
  logic ce = 1'b1;
  logic nv_load = 1'b0;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic signed [15:0] raw_data = 16'sh0;
  logic signed [15:0] meas_off = 16'sh0;
  logic signed [15:0] data;
  logic [2:0] raw_chan = 3'h0;
  logic [2:0] conv_chan, data_chan;
  logic [1:0] bg_track;
  int fails = 0;
  int cmp_count = 0;

  // 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;

  acd_cal_datapath u_acd_cal_datapath (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .raw_valid_i(raw_valid), .raw_chan_i(raw_chan), .raw_data_i(raw_data),
    .meas_valid_i(meas_valid), .meas_set_i(2'h0),
    .meas_offset_i(meas_off), .meas_gain_i(16'h8000),
    .nv_load_i(nv_load), .nv_set_i(2'h0), .nv_offset_i(16'sh0),
    .nv_gain_i(16'h8000), .conv_restart_o(conv_restart),
    .conv_chan_o(conv_chan), .cal_slot_o(cal_slot), .bg_track_o(bg_track),
    .data_valid_o(data_valid), .data_chan_o(data_chan), .data_o(data)
  );

  acd_host_model u_acd_host_model (
    .ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_acd_host_model.wr_reg(a, d);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    u_acd_host_model.rd_reg(a, q);
    chk(q, exp);
  endtask : rd_chk

  // Background measurement for set 0, unity gain
  task automatic meas(input logic signed [15:0] off);
    @(posedge ref_clk_i);
    #1;
    meas_valid = 1'b1;
    meas_off = off;
    @(posedge ref_clk_i);
    #1;
    meas_valid = 1'b0;
    meas_off = ~off;
  endtask : meas

  // One raw result, then a bounded wait for the word (or its absence)
  task automatic conv(input logic [2:0] ch, input logic [15:0] d,
                      input logic [15:0] exp, input logic out);
    int i;
    @(posedge ref_clk_i);
    #1;
    raw_valid = 1'b1;
    raw_chan = ch;
    raw_data = d;
    @(posedge ref_clk_i);
    #1;
    raw_valid = 1'b0;
    raw_data = ~d;
    slot = cal_slot;
    for (i = 0; i < 48 && data_valid !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      #1;
      slot = slot | cal_slot;
    end
    if (out && i == 48) begin
      fails++;
      tally_and_finish();
    end
    chk({15'h0, data_valid}, {15'h0, out});
    if (out) begin
      chk(data, exp);
      chk({13'h0, data_chan}, {13'h0, ch});
    end
  endtask : conv

  // Reset values and an unmapped address that ignores writes
  task automatic t_reset();
    logic [6:0] a [6] = '{7'h01, 7'h10, 7'h11, 7'h12, 7'h13, 7'h7f};
    logic [15:0] e [6] = '{16'h0, 16'h0, 16'h8000, 16'h1, 16'h0, 16'h0};
    wr(7'h7f, 16'hffff);
    // A write while the clock enable is low must be dropped
    ce = 1'b0;
    wr(7'h10, 16'h5555);
    ce = 1'b1;
    foreach (a[k]) rd_chk(a[k], e[k]);
  endtask : t_reset

  // Every background setting, then correction versus estimation
  task automatic t_bg();
    logic [1:0] trk [4] = '{2'b00, 2'b01, 2'b11, 2'b00};
    for (int m = 0; m < 4; m++) begin
      wr(7'h00, {14'h0, m[1:0]});
      #9;
      chk({14'h0, bg_track}, {14'h0, trk[m]});
    end
    wr(7'h00, {14'h0, BG_OFFSET_GAIN_CORRECT});
    meas(16'sh0010);
    conv(3'h4, 16'h0110, 16'h0100, 1'b1);
    chk({15'h0, slot}, 16'h0001);
    // Amplifier calibration on: no extra slot is asked for
    wr(7'h03, 16'h0001);
    conv(3'h4, 16'h0110, 16'h0100, 1'b1);
    chk({15'h0, slot}, 16'h0000);
    wr(7'h03, 16'h0000);
    wr(7'h00, {14'h0, BG_OFFSET_GAIN_ESTIMATE});
    meas(16'sh0020);
    conv(3'h0, 16'h0110, 16'h0100, 1'b1);
    chk({15'h0, slot}, 16'h0000);
    // Factory load replaces the held offset while estimating
    @(posedge ref_clk_i);
    #1;
    nv_load = 1'b1;
    @(posedge ref_clk_i);
    #1;
    nv_load = 1'b0;
    conv(3'h0, 16'h0110, 16'h0110, 1'b1);
    wr(7'h00, {14'h0, BG_CAL_OFF});
  endtask : t_bg

  // System offset then gain division, with saturation both ways
  task automatic t_sys();
    wr(7'h14, 16'h0100);
    wr(7'h15, 16'h4000);
    rd_chk(7'h14, 16'h0100);
    conv(3'h5, 16'h0200, 16'h0200, 1'b1);
    conv(3'h1, 16'h7000, 16'h7fff, 1'b1);
    conv(3'h1, 16'h8000, 16'h8000, 1'b1);
  endtask : t_sys

  // Multiply by 3, shift by 1, for both signs
  task automatic t_scale();
    u_acd_host_model.set_scale(2'h3, 16'h0003, 4'h1);
    conv(3'h3, 16'h0100, 16'h0180, 1'b1);
    conv(3'h3, 16'hff00, 16'hfe80, 1'b1);
  endtask : t_scale

  // Offset run, gain run, then a result on the aliased channel
  task automatic t_det();
    u_acd_host_model.det_offset(3'h2);
    chk({13'h0, conv_chan}, 16'h0002);
    conv(3'h2, 16'h004e, 16'h0, 1'b0);
    rd_chk(7'h18, 16'h004e);
    rd_chk(7'h01, 16'h0000);
    // Second run, then the host writes back the mean of both
    u_acd_host_model.det_offset(3'h2);
    conv(3'h2, 16'h0052, 16'h0, 1'b0);
    rd_chk(7'h18, 16'h0052);
    wr(7'h18, 16'h0050);
    rd_chk(7'h18, 16'h0050);
    u_acd_host_model.det_gain(2'h2, 16'h2000);
    conv(3'h2, 16'h1050, 16'h0, 1'b0);
    rd_chk(7'h19, 16'h4000);
    rd_chk(7'h01, 16'h0000);
    conv(3'h6, 16'h1050, 16'h2000, 1'b1);
  endtask : t_det

  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_bg();
    t_sys();
    t_scale();
    t_det();
    tally_and_finish();
  end
endmodule : testbench
